// ### common/cmp_cfg_pkg.sv
// Constants for the comparator configuration register bank
package cmp_cfg_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] CMP0_MUX_ADDR  = 8'h9c;
  localparam logic [7:0] CMP1_MODE_ADDR = 8'h9e;
  localparam logic [7:0] CMP1_MUX_ADDR  = 8'h9f;

  // Reset values
  localparam logic [7:0] CMP1_MODE_RST = 8'h02;
  localparam logic [7:0] CMP_MUX_RST   = 8'h77;

  // Field positions in the mode register
  localparam int RISE_EN_BIT = 5;
  localparam int FALL_EN_BIT = 4;
  localparam int SPEED_LSB   = 0;

  // Field positions in the multiplexer registers
  localparam int POS_LSB = 0;
  localparam int NEG_LSB = 4;

  // Writable bits of the mode register
  localparam logic [7:0] CMP1_MODE_WMASK = 8'h33;

  // Pins per multiplexer side, highest pin code, and the highest code the small
  // package bonds
  localparam int          MUX_PINS      = 12;
  localparam logic [3:0]  MUX_LAST_CODE = 4'hb;
  localparam logic [3:0]  SMALL_LAST    = 4'h8;

endpackage

// ### hw/cmp_cfg_regs.sv
// Comparator 1 mode and comparator input multiplexer register bank
`timescale 1ns/1ns

module cmp_cfg_regs
  import cmp_cfg_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1           // Package bonds P2.2..P2.7
)
(
  input  wire logic                clk,          // System clock 100 MHz
  input  wire logic                rst_n,        // Synchronous reset
  input  wire logic [7:0]          sfrAddr,      // Register address
  input  wire logic                sfrWr,        // Write strobe
  input  wire logic                sfrRd,        // Read strobe
  input  wire logic [7:0]          sfrWdata,     // Write data
  input  wire logic                riseEvt,      // Comparator 1 rising edge
  input  wire logic                fallEvt,      // Comparator 1 falling edge
  input  wire logic                riseFlagClr,  // Software clears rise flag
  input  wire logic                fallFlagClr,  // Software clears fall flag
  output logic [7:0]               sfrRdata,     // Read data, registered
  output logic                     cmp1Irq,      // Comparator 1 interrupt
  output logic                     cmp1RiseFlag, // Sticky rising-edge flag
  output logic                     cmp1FallFlag, // Sticky falling-edge flag
  output logic [1:0]               cmp1SpeedPowerSel, // Response mode
  output logic [MUX_PINS-1:0]      cmp0PosPins,  // One-hot even-pin select
  output logic [MUX_PINS-1:0]      cmp0NegPins,  // One-hot odd-pin select
  output logic [MUX_PINS-1:0]      cmp1PosPins,  // One-hot even-pin select
  output logic [MUX_PINS-1:0]      cmp1NegPins   // One-hot odd-pin select
);

  //--------------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------------
  logic [7:0] cmp1ModeReg_ff;
  logic [7:0] cmp0MuxReg_ff;
  logic [7:0] cmp1MuxReg_ff;
  logic       rdHit;
  logic [7:0] nxt_rdata;
  logic       wrMode;
  logic       wrMux0;
  logic       wrMux1;

  //--------------------------------------------------------------------
  // Write decode
  //--------------------------------------------------------------------
  // A write lands only where strobe and an exact address match coincide
  assign wrMode = sfrWr && (sfrAddr == CMP1_MODE_ADDR);
  assign wrMux0 = sfrWr && (sfrAddr == CMP0_MUX_ADDR);
  assign wrMux1 = sfrWr && (sfrAddr == CMP1_MUX_ADDR);

  // Unused mode bits are dropped on the way in, so they never read back
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1ModeReg_ff <= CMP1_MODE_RST;
    else if (wrMode)
      cmp1ModeReg_ff <= sfrWdata & CMP1_MODE_WMASK;
  end

  // Each comparator owns its mux register; no write touches the other
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp0MuxReg_ff <= CMP_MUX_RST;
    else if (wrMux0)
      cmp0MuxReg_ff <= sfrWdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1MuxReg_ff <= CMP_MUX_RST;
    else if (wrMux1)
      cmp1MuxReg_ff <= sfrWdata;
  end

  //--------------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------------
  always_comb
  begin
    rdHit     = 1'b1;
    nxt_rdata = 8'h00;
    unique case (sfrAddr)
      CMP0_MUX_ADDR:  nxt_rdata = cmp0MuxReg_ff;
      CMP1_MODE_ADDR: nxt_rdata = cmp1ModeReg_ff & CMP1_MODE_WMASK;
      CMP1_MUX_ADDR:  nxt_rdata = cmp1MuxReg_ff;
      default:        rdHit     = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sfrRdata <= 8'h00;
    else if (sfrRd)
      sfrRdata <= rdHit ? nxt_rdata : 8'h00;
  end

  //--------------------------------------------------------------------
  // Edge flags and interrupt gating
  //--------------------------------------------------------------------
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1RiseFlag <= 1'b0;
    else
      cmp1RiseFlag <= riseEvt | (cmp1RiseFlag & ~riseFlagClr);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1FallFlag <= 1'b0;
    else
      cmp1FallFlag <= fallEvt | (cmp1FallFlag & ~fallFlagClr);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1Irq <= 1'b0;
    else
      cmp1Irq <= (cmp1RiseFlag & cmp1ModeReg_ff[RISE_EN_BIT])
               | (cmp1FallFlag & cmp1ModeReg_ff[FALL_EN_BIT]);
  end

  //--------------------------------------------------------------------
  // Static control outputs
  //--------------------------------------------------------------------
  // Outputs lag the register by one edge so the analog side sees a
  // clean, glitch-free level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmp1SpeedPowerSel <= CMP1_MODE_RST[SPEED_LSB +: 2];
    else
      cmp1SpeedPowerSel <= cmp1ModeReg_ff[SPEED_LSB +: 2];
  end

  cmp_pin_decode #(
    .PINS      (MUX_PINS),
    .LARGE_PKG (LARGE_PKG)
  ) i_cmp0_pos (
    .clk   (clk),
    .rst_n (rst_n),
    .code  (cmp0MuxReg_ff[POS_LSB +: 4]),
    .pins  (cmp0PosPins)
  );

  cmp_pin_decode #(
    .PINS      (MUX_PINS),
    .LARGE_PKG (LARGE_PKG)
  ) i_cmp0_neg (
    .clk   (clk),
    .rst_n (rst_n),
    .code  (cmp0MuxReg_ff[NEG_LSB +: 4]),
    .pins  (cmp0NegPins)
  );

  cmp_pin_decode #(
    .PINS      (MUX_PINS),
    .LARGE_PKG (LARGE_PKG)
  ) i_cmp1_pos (
    .clk   (clk),
    .rst_n (rst_n),
    .code  (cmp1MuxReg_ff[POS_LSB +: 4]),
    .pins  (cmp1PosPins)
  );

  cmp_pin_decode #(
    .PINS      (MUX_PINS),
    .LARGE_PKG (LARGE_PKG)
  ) i_cmp1_neg (
    .clk   (clk),
    .rst_n (rst_n),
    .code  (cmp1MuxReg_ff[NEG_LSB +: 4]),
    .pins  (cmp1NegPins)
  );

endmodule

// Turns one 4-bit mux code into a registered one-hot pin select
module cmp_pin_decode
  import cmp_cfg_pkg::*;
#(
  parameter int PINS      = MUX_PINS, // Pins on one side of a mux
  parameter bit LARGE_PKG = 1'b1      // Package bonds the top three pins
)
(
  input  wire logic            clk,   // System clock
  input  wire logic            rst_n, // Synchronous reset
  input  wire logic [3:0]      code,  // Stored selection code
  output logic [PINS-1:0]      pins   // One-hot pin select
);

  logic [PINS-1:0] nxt_pins;

  // Bit i is the i-th even pin on the positive side, the i-th odd pin on
  // the negative side; codes past the last or the bonded pins pick none
  always_comb
  begin
    nxt_pins = '0;
    if (code <= MUX_LAST_CODE && (LARGE_PKG || code <= SMALL_LAST))
      nxt_pins[code] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pins <= '0;
    else
      pins <= nxt_pins;
  end

endmodule

// ### tb/cmp_cfg_regs_chk.sv
// Checks on the comparator config registers
`timescale 1ns/1ns
module cmp_cfg_regs_chk
  import cmp_cfg_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1             // Top three pin codes bonded
)
(
  input wire logic        clk,               // Clock
  input wire logic        rst_n,             // Reset
  input wire logic [7:0]  sfrAddr,           // Address
  input wire logic        sfrWr,             // Write
  input wire logic        sfrRd,             // Read
  input wire logic [7:0]  sfrWdata,          // Wdata
  input wire logic        riseEvt,           // Event
  input wire logic        fallEvt,           // Event
  input wire logic [7:0]  sfrRdata,          // Rdata
  input wire logic        cmp1Irq,           // Irq
  input wire logic        cmp1RiseFlag,      // Flag
  input wire logic        cmp1FallFlag,      // Flag
  input wire logic [1:0]  cmp1SpeedPowerSel, // Mode
  input wire logic [11:0] cmp0PosPins,       // Pins
  input wire logic [11:0] cmp1NegPins        // Pins
);
  wire       w0 = sfrWr && sfrAddr == CMP0_MUX_ADDR;
  wire       w1 = sfrWr && sfrAddr == CMP1_MUX_ADDR;
  wire       wm = sfrWr && sfrAddr == CMP1_MODE_ADDR;
  wire [3:0] lo = sfrWdata[3:0];
  wire [3:0] hi = sfrWdata[7:4];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_zero: assert property (sfrRd && sfrAddr == CMP1_MODE_ADDR
    |=> !(sfrRdata & 8'hcc)) else $error("unused mode bits set");
  a_speed_follow: assert property (
    wm |=> ##1 cmp1SpeedPowerSel == $past(sfrWdata[1:0], 2))
    else $error("mode output wrong");
  a_rise_flag: assert property (riseEvt |=> cmp1RiseFlag)
    else $error("rise flag not set");
  a_fall_flag: assert property (fallEvt |=> cmp1FallFlag)
    else $error("fall flag not set");
  a_irq_cause: assert property (
    $rose(cmp1Irq) |-> $past(cmp1RiseFlag | cmp1FallFlag))
    else $error("irq without flag");
  a_pos_hot: assert property (
    w0 && lo < MUX_PINS && (LARGE_PKG || lo <= SMALL_LAST)
    |=> ##1 cmp0PosPins == 12'h001 << $past(lo, 2))
    else $error("pos pin wrong");
  a_pos_none: assert property (
    w0 && (lo >= MUX_PINS || (!LARGE_PKG && lo > SMALL_LAST))
    |=> ##1 cmp0PosPins == 12'h000)
    else $error("pos pin not idle");
  a_neg_hot: assert property (
    w1 && hi < MUX_PINS && (LARGE_PKG || hi <= SMALL_LAST)
    |=> ##1 cmp1NegPins == 12'h001 << $past(hi, 2))
    else $error("neg pin wrong");
  a_mux_indep: assert property (w1 |=> ##1 $stable(cmp0PosPins))
    else $error("mux cross coupling");
  cover property (wm);
  cover property (cmp1Irq);
  cover property (w1 && hi >= MUX_PINS);
endmodule
bind cmp_cfg_regs cmp_cfg_regs_chk #(.LARGE_PKG(LARGE_PKG)) i_chk (.*);

// ### tb/sfr_host.sv
// Core-side model that drives the register bus
`timescale 1ns/1ns
module sfr_host
(
  input  wire logic       clk,      // Clock
  input  wire logic [7:0] sfrRdata, // Read data
  output logic [7:0]      sfrAddr,  // Address
  output logic            sfrWr,    // Write strobe
  output logic            sfrRd,    // Read strobe
  output logic [7:0]      sfrWdata  // Write data
);
  initial {sfrAddr, sfrWr, sfrRd, sfrWdata} = 18'h0_0000;
  // Software is taken to set mux-chosen pins analog, crossbar-skipped
  // Released lines show the inverse so stale values never match
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {sfrAddr, sfrWdata, sfrWr} = {a, d, 1'b1};
    @(posedge clk) #1 {sfrAddr, sfrWdata, sfrWr} = {~a, ~d, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 {sfrAddr, sfrRd} = {a, 1'b1};
    @(posedge clk) #1 {sfrAddr, sfrRd} = {~a, 1'b0};
    d = sfrRdata;
  endtask
endmodule

// ### tb/tb_cmp_cfg_regs.sv
// Bench for the comparator config register bank
`timescale 1ns/1ns
module tb_cmp_cfg_regs
  import cmp_cfg_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, riseEvt = 1'b0, fallEvt = 1'b0;
  logic        riseFlagClr = 1'b0, fallFlagClr = 1'b0, sfrWr, sfrRd;
  logic        cmp1Irq, cmp1RiseFlag, cmp1FallFlag;
  logic [1:0]  cmp1SpeedPowerSel;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, d, v;
  logic [11:0] cmp0PosPins, cmp0NegPins, cmp1PosPins, cmp1NegPins;
  logic [11:0] smallPos, smallNeg;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  sfr_host i_host (.*);
  cmp_cfg_regs i_dut (.*);
  cmp_cfg_regs #(.LARGE_PKG(1'b0)) i_dut_small (
    .clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .riseEvt(riseEvt),
    .fallEvt(fallEvt), .riseFlagClr(riseFlagClr),
    .fallFlagClr(fallFlagClr), .sfrRdata(), .cmp1Irq(),
    .cmp1RiseFlag(), .cmp1FallFlag(), .cmp1SpeedPowerSel(),
    .cmp0PosPins(smallPos), .cmp0NegPins(smallNeg), .cmp1PosPins(),
    .cmp1NegPins());
  function automatic logic [11:0] hot(input logic [3:0] c,
                                      input bit big = 1'b1);
    return (c < MUX_PINS && (big || c <= SMALL_LAST)) ? 12'h001 << c
                                                      : 12'h000;
  endfunction
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [11:0] e, input logic [11:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task evt(input logic r, input logic e);
    {riseEvt, fallEvt} = {r, !r};
    tick(1);
    {riseEvt, fallEvt} = 2'b00;
    tick(2);
    chk(12'(e), 12'(cmp1Irq));
    chk(12'h001, 12'(r ? cmp1RiseFlag : cmp1FallFlag));
    {riseFlagClr, fallFlagClr} = {r, !r};
    tick(1);
    {riseFlagClr, fallFlagClr} = 2'b00;
    chk(12'h000, 12'(r ? cmp1RiseFlag : cmp1FallFlag));
  endtask
  always @(posedge clk)
    if (++cyc == 2000)
    begin
      error_cnt++;
      test_done;
    end
  initial
  begin
    void'($urandom(97327));
    tick(8);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      i_host.rd(8'h9c + 8'(i), v);
      chk(12'(i == 1 ? 8'h00 : i == 2 ? CMP1_MODE_RST : CMP_MUX_RST),
          12'(v));
    end
    chk(hot(4'h7), cmp0PosPins);
    for (int i = 0; i < 16; i++)
    begin
      i_host.wr(CMP0_MUX_ADDR, {4'(i), 4'(i)});
      i_host.wr(CMP1_MUX_ADDR, {4'(15 - i), 4'(i)});
      tick(1);
      chk(hot(4'(i)), cmp0PosPins);
      chk(hot(4'(i)), cmp0NegPins);
      chk(hot(4'(i)), cmp1PosPins);
      chk(hot(4'(15 - i)), cmp1NegPins);
      chk(hot(4'(i), 1'b0), smallPos);
      chk(hot(4'(i), 1'b0), smallNeg);
      i_host.rd(CMP1_MUX_ADDR, v);
      chk(12'({4'(15 - i), 4'(i)}), 12'(v));
    end
    repeat (20)
    begin
      d = 8'($urandom);
      i_host.wr(CMP1_MODE_ADDR, d);
      tick(1);
      chk(12'(d[1:0]), 12'(cmp1SpeedPowerSel));
      i_host.rd(CMP1_MODE_ADDR, v);
      chk(12'(d & CMP1_MODE_WMASK), 12'(v));
    end
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(CMP1_MODE_ADDR, 8'(i << 4));
      evt(1'b1, i[1]);
      evt(1'b0, i[0]);
    end
    {riseEvt, riseFlagClr} = 2'b11;
    tick(1);
    {riseEvt, riseFlagClr} = 2'b00;
    chk(12'h001, 12'(cmp1RiseFlag));
    riseFlagClr = 1'b1;
    tick(1);
    riseFlagClr = 1'b0;
    chk(12'h000, 12'(cmp1RiseFlag));
    i_host.wr(CMP0_MUX_ADDR, 8'h00);
    i_host.wr(CMP1_MODE_ADDR, 8'h33);
    rst_n = 1'b0;
    tick(2);
    chk(12'h000, cmp0PosPins);
    rst_n = 1'b1;
    tick(1);
    chk(hot(4'h7), cmp0PosPins);
    i_host.rd(CMP1_MODE_ADDR, v);
    chk(12'(CMP1_MODE_RST), 12'(v));
    test_done;
  end
endmodule
